// ### design/pcrs_top.sv
// Purpose: program counter, latch registers and 31-level hardware return stack
// Assumes: core and bus on one clock; core issues at most one operation a cycle
// Notes:   a bus access in the same cycle as a core operation wins on shared state, except a hardware set of a sticky flag
`timescale 1ns/100ps
`default_nettype none
module pcrs_top
    import pcrs_pkg::*;
#(
    parameter int MEM_KBYTES = 16                    // 8 or 16
) (
    input  wire logic         clock,                 // core clock, 10 MHz
    input  wire logic         rst_n,                 // async reset, active low
    input  wire logic         wb_cyc_i,              // bus cycle
    input  wire logic         wb_stb_i,              // bus strobe
    input  wire logic         wb_we_i,               // bus write
    input  wire logic [3:0]   wb_sel_i,              // byte lanes
    input  wire logic [7:0]   wb_adr_i,              // byte address
    input  wire logic [31:0]  wb_dat_i,              // write data
    output logic       [31:0] wb_dat_o,              // read data
    output logic              wb_ack_o,              // bus acknowledge
    input  wire pcrs_op_type  coreOp,                // core operation
    input  wire logic [20:0]  coreTarget,            // branch or call target
    input  wire logic [15:0]  progData,              // memory word at fetchAddr
    output logic       [20:0] fetchAddr,             // program counter
    output logic       [15:0] instrWord,             // fetched word, zero if absent
    output logic              stackFull,             // pointer at 31
    output logic              stackOverflow,         // sticky
    output logic              stackUnderflow         // sticky
);
    localparam logic [21:0] MEM_LIMIT = 22'(MEM_KBYTES * KBYTE);

    typedef struct packed {
        logic [20:0]                pc;
        logic [7:0]                 highLatch;
        logic [7:0]                 upperLatch;
        logic [4:0]                 ptr;
        logic                       full;
        logic                       ovf;
        logic                       unf;
        logic [STACK_DEPTH:1][20:0] stack;
        logic                       ack;
        logic [31:0]                rdat;
        logic [15:0]                instr;
    } pcrs_state_type;

    pcrs_state_type st_ff;
    pcrs_state_type nxt_st;

    // entry at the pointer, zero when the stack is empty
    function automatic logic [20:0] topEntry(input pcrs_state_type s);
        if (s.ptr == SP_EMPTY) begin
            return 21'h000000;
        end
        return s.stack[s.ptr];
    endfunction

    // true when an address lies inside the implemented memory
    function automatic logic inMemory(input logic [20:0] a);
        return {1'b0, a} < MEM_LIMIT;
    endfunction

    logic busReq;
    logic busWr;
    logic busRd;
    assign busReq = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign busWr  = busReq && wb_we_i && wb_sel_i[0];
    assign busRd  = busReq && !wb_we_i;

    // next state: core operation first, then bus access
    always_comb begin
        logic [20:0] top;
        logic        ovfSet;
        logic        unfSet;
        top    = topEntry(st_ff);
        ovfSet = 1'b0;
        unfSet = 1'b0;
        nxt_st = st_ff;
        // fetch data gated so absent memory reads as no_operation
        nxt_st.instr = inMemory(st_ff.pc) ? progData : 16'h0000;
        unique case (coreOp)
            OP_NONE: begin
            end
            OP_ADVANCE: begin
                nxt_st.pc = st_ff.pc + WORD_STEP;
            end
            OP_BRANCH: begin
                nxt_st.pc = {coreTarget[20:1], 1'b0};
            end
            OP_CALL, OP_RELCALL, OP_INT_HI, OP_INT_LO: begin
                // push: pointer first, then the entry it now names
                if (st_ff.ptr == SP_FULL) begin
                    ovfSet     = 1'b1;
                    nxt_st.ovf = 1'b1;
                end else begin
                    nxt_st.ptr = st_ff.ptr + 5'h01;
                    nxt_st.stack[st_ff.ptr + 5'h01] = st_ff.pc;
                end
                if (coreOp == OP_INT_HI) begin
                    nxt_st.pc = HIGH_INT_VECT;
                end else if (coreOp == OP_INT_LO) begin
                    nxt_st.pc = LOW_INT_VECT;
                end else begin
                    nxt_st.pc = {coreTarget[20:1], 1'b0};
                end
            end
            OP_RETURN, OP_RETLIT, OP_RETINT: begin
                // pop: read the entry, then step the pointer back
                nxt_st.pc = {top[20:1], 1'b0};
                if (st_ff.ptr == SP_EMPTY) begin
                    unfSet     = 1'b1;
                    nxt_st.unf = 1'b1;
                end else begin
                    nxt_st.ptr = st_ff.ptr - 5'h01;
                end
            end
            default: begin
            end
        endcase
        // bus writes; hardware set of a sticky flag wins over a clear
        if (busWr) begin
            unique case (wb_adr_i)
                OFS_LOW_BYTE: begin
                    nxt_st.pc = {st_ff.upperLatch[4:0], st_ff.highLatch,
                                 wb_dat_i[7:1], 1'b0};
                end
                OFS_HIGH_LATCH: begin
                    nxt_st.highLatch = wb_dat_i[7:0];
                end
                OFS_UPPER_LATCH: begin
                    nxt_st.upperLatch = wb_dat_i[7:0];
                end
                OFS_STACK_PTR: begin
                    nxt_st.ptr = wb_dat_i[4:0];
                    nxt_st.ovf = (st_ff.ovf & wb_dat_i[SPR_OVF_BIT]) | ovfSet;
                    nxt_st.unf = (st_ff.unf & wb_dat_i[SPR_UNF_BIT]) | unfSet;
                end
                OFS_TOP_UPPER: begin
                    if (st_ff.ptr != SP_EMPTY) begin
                        nxt_st.stack[st_ff.ptr][20:16] = wb_dat_i[4:0];
                    end
                end
                OFS_TOP_HIGH: begin
                    if (st_ff.ptr != SP_EMPTY) begin
                        nxt_st.stack[st_ff.ptr][15:8] = wb_dat_i[7:0];
                    end
                end
                OFS_TOP_LOW: begin
                    if (st_ff.ptr != SP_EMPTY) begin
                        nxt_st.stack[st_ff.ptr][7:0] = wb_dat_i[7:0];
                    end
                end
                default: begin
                end
            endcase
        end
        // bus reads; unmapped offsets answer zero
        nxt_st.rdat = 32'h00000000;
        if (busRd) begin
            unique case (wb_adr_i)
                OFS_LOW_BYTE: begin
                    nxt_st.rdat       = {24'h000000, st_ff.pc[7:0]};
                    nxt_st.highLatch  = st_ff.pc[15:8];
                    nxt_st.upperLatch = {3'h0, st_ff.pc[20:16]};
                end
                OFS_HIGH_LATCH: begin
                    nxt_st.rdat = {24'h000000, st_ff.highLatch};
                end
                OFS_UPPER_LATCH: begin
                    nxt_st.rdat = {24'h000000, st_ff.upperLatch};
                end
                OFS_STACK_PTR: begin
                    nxt_st.rdat = {24'h000000, st_ff.ovf, st_ff.unf,
                                   st_ff.ptr == SP_FULL, st_ff.ptr};
                end
                OFS_TOP_UPPER: begin
                    nxt_st.rdat = {27'h0000000, top[20:16]};
                end
                OFS_TOP_HIGH: begin
                    nxt_st.rdat = {24'h000000, top[15:8]};
                end
                OFS_TOP_LOW: begin
                    nxt_st.rdat = {24'h000000, top[7:0]};
                end
                default: begin
                end
            endcase
        end
        // one-cycle ack, dropped the cycle after
        nxt_st.ack = busReq;
        // full kept as a flop so the pin carries no decode
        nxt_st.full = nxt_st.ptr == SP_FULL;
    end

    // single state register; whole state cleared, stack storage included
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_ff            <= '0;
            st_ff.pc         <= RESET_VECTOR;
            st_ff.ptr        <= SP_EMPTY;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from the state register
    assign wb_dat_o       = st_ff.rdat;
    assign wb_ack_o       = st_ff.ack;
    assign fetchAddr      = st_ff.pc;
    assign instrWord      = st_ff.instr;
    assign stackFull      = st_ff.full;
    assign stackOverflow  = st_ff.ovf;
    assign stackUnderflow = st_ff.unf;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    property p_align;
        fetchAddr[0] == 1'b0;
    endproperty
    a_align: assert property (p_align) else $error("counter misaligned");

    property p_advance;
        (coreOp == OP_ADVANCE && !busWr) |=> fetchAddr == $past(fetchAddr) + WORD_STEP;
    endproperty
    a_advance: assert property (p_advance) else $error("advance not by two");

    property p_int_hi;
        (coreOp == OP_INT_HI && !busWr) |=> fetchAddr == HIGH_INT_VECT;
    endproperty
    a_int_hi: assert property (p_int_hi) else $error("high vector wrong");

    property p_push;
        (coreOp == OP_CALL && st_ff.ptr != SP_FULL && !busWr)
            |=> st_ff.ptr == $past(st_ff.ptr) + 5'h01 && st_ff.stack[st_ff.ptr] == $past(fetchAddr);
    endproperty
    a_push: assert property (p_push) else $error("push wrong");

    property p_call_ret;
        (coreOp == OP_CALL && st_ff.ptr != SP_FULL && !busWr) ##1
            (coreOp == OP_RETURN && !busWr) |=> fetchAddr == $past(fetchAddr, 2);
    endproperty
    a_call_ret: assert property (p_call_ret) else $error("return address lost");

    property p_pop;
        (coreOp == OP_RETURN && st_ff.ptr != SP_EMPTY && !busWr)
            |=> st_ff.ptr == $past(st_ff.ptr) - 5'h01;
    endproperty
    a_pop: assert property (p_pop) else $error("pop pointer wrong");

    property p_latch_copy;
        (busRd && wb_adr_i == OFS_LOW_BYTE) |=> st_ff.highLatch == $past(fetchAddr[15:8]);
    endproperty
    a_latch_copy: assert property (p_latch_copy) else $error("latch not copied");

    property p_latch_keep;
        (coreOp inside {OP_CALL, OP_RETURN} && !busReq) |=> $stable(st_ff.highLatch);
    endproperty
    a_latch_keep: assert property (p_latch_keep) else $error("latch disturbed");

    property p_zero_fetch;
        !inMemory(fetchAddr) |=> instrWord == 16'h0000;
    endproperty
    a_zero_fetch: assert property (p_zero_fetch) else $error("absent memory not zero");

    property p_ovf_sticky;
        (stackOverflow && !(busWr && wb_adr_i == OFS_STACK_PTR)) |=> stackOverflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");

    property p_ack_once;
        wb_ack_o |=> !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held two cycles");

    property p_int_lo;
        (coreOp == OP_INT_LO && !busWr) |=> fetchAddr == LOW_INT_VECT;
    endproperty
    a_int_lo: assert property (p_int_lo) else $error("low vector wrong");

    property p_branch;
        (coreOp == OP_BRANCH && !busWr) |=> fetchAddr == {$past(coreTarget[20:1]), 1'b0};
    endproperty
    a_branch: assert property (p_branch) else $error("branch target wrong");

    property p_low_write;
        (busWr && wb_adr_i == OFS_LOW_BYTE) |=> fetchAddr == {$past(st_ff.upperLatch[4:0]),
            $past(st_ff.highLatch), $past(wb_dat_i[7:1]), 1'b0};
    endproperty
    a_low_write: assert property (p_low_write) else $error("latches not loaded");

    property p_ovf_set;
        (coreOp inside {OP_CALL, OP_RELCALL, OP_INT_HI, OP_INT_LO} && st_ff.ptr == SP_FULL)
            |=> stackOverflow;
    endproperty
    a_ovf_set: assert property (p_ovf_set) else $error("overflow not raised");

    property p_unf_set;
        (coreOp inside {OP_RETURN, OP_RETLIT, OP_RETINT} && st_ff.ptr == SP_EMPTY)
            |=> stackUnderflow;
    endproperty
    a_unf_set: assert property (p_unf_set) else $error("underflow not raised");

    property p_unf_sticky;
        (stackUnderflow && !(busWr && wb_adr_i == OFS_STACK_PTR)) |=> stackUnderflow;
    endproperty
    a_unf_sticky: assert property (p_unf_sticky) else $error("underflow flag lost");

    property p_full;
        stackFull == (st_ff.ptr == SP_FULL);
    endproperty
    a_full: assert property (p_full) else $error("full flag wrong");

    property p_top_low;
        (busRd && wb_adr_i == OFS_TOP_LOW && st_ff.ptr != SP_EMPTY)
            |=> wb_dat_o == {24'h000000, $past(st_ff.stack[st_ff.ptr][7:0])};
    endproperty
    a_top_low: assert property (p_top_low) else $error("top low read wrong");

    property p_ptr_write;
        (busWr && wb_adr_i == OFS_STACK_PTR) |=> st_ff.ptr == $past(wb_dat_i[4:0]);
    endproperty
    a_ptr_write: assert property (p_ptr_write) else $error("pointer write lost");
endmodule
`default_nettype wire

// ### pkg/pcrs_pkg.sv
// Purpose: shared constants and types for the program counter and return stack
// Assumes: 32-bit classic Wishbone register bus, one core clock
// Notes:   register offsets are byte addresses, one aligned word each
package pcrs_pkg;
    localparam int PC_W        = 21;                 // counter width
    localparam int SP_W        = 5;                  // stack pointer width
    localparam int STACK_DEPTH = 31;                 // entries 1..31, zero is empty
    localparam int KBYTE       = 1024;

    // register offsets
    localparam logic [7:0] OFS_LOW_BYTE    = 8'h00;
    localparam logic [7:0] OFS_HIGH_LATCH  = 8'h04;
    localparam logic [7:0] OFS_UPPER_LATCH = 8'h08;
    localparam logic [7:0] OFS_STACK_PTR   = 8'h0C;
    localparam logic [7:0] OFS_TOP_UPPER   = 8'h10;
    localparam logic [7:0] OFS_TOP_HIGH    = 8'h14;
    localparam logic [7:0] OFS_TOP_LOW     = 8'h18;

    // stack pointer register field positions
    localparam int SPR_FULL_BIT = 5;
    localparam int SPR_UNF_BIT  = 6;
    localparam int SPR_OVF_BIT  = 7;

    // vectors and reset values
    localparam logic [20:0] RESET_VECTOR   = 21'h000000;
    localparam logic [20:0] HIGH_INT_VECT  = 21'h000008;
    localparam logic [20:0] LOW_INT_VECT   = 21'h000018;
    localparam logic [20:0] WORD_STEP      = 21'h000002;
    localparam logic [4:0]  SP_EMPTY       = 5'h00;
    localparam logic [4:0]  SP_FULL        = 5'h1F;

    // operations presented by the execution core, one per cycle
    typedef enum logic [3:0] {
        OP_NONE    = 4'h0,
        OP_ADVANCE = 4'h1,
        OP_BRANCH  = 4'h2,   // goto and branches
        OP_CALL    = 4'h3,
        OP_RELCALL = 4'h4,   // relative_call
        OP_RETURN  = 4'h5,
        OP_RETLIT  = 4'h6,   // return_with_literal
        OP_RETINT  = 4'h7,   // return_from_interrupt
        OP_INT_HI  = 4'h8,
        OP_INT_LO  = 4'h9
    } pcrs_op_type;

    typedef struct packed {
        pcrs_op_type  op;
        logic [20:0]  target;
    } pcrs_core_req_type;

    typedef struct packed {
        logic         cyc;
        logic         stb;
        logic         we;
        logic [3:0]   sel;
        logic [7:0]   adr;
        logic [31:0]  dat;
    } pcrs_wb_req_type;
endpackage

// ### testbench/pcrs_prog_mem.sv
// Purpose: program memory model for the counter block
// Assumes: any byte address answers with a word
// Notes:   words are never zero, so a zero fetch shows masking
`timescale 1ns/100ps
`default_nettype none
module pcrs_prog_mem (
    input  wire logic [20:0] fetchAddr, // byte address
    output logic      [15:0] progData   // word at that address
);
    // top bit set keeps every word non-zero, even past the boundary
    assign progData = {1'b1, ~fetchAddr[15:1]};
endmodule
`default_nettype wire

// ### testbench/pcrs_top_tb.sv
// Purpose: self-checking bench for the counter and return stack
// Assumes: 8- and 16-Kbyte builds side by side, bus answers after one edge
// Notes:   each core operation is held for exactly one edge
`timescale 1ns/100ps
`default_nettype none
module pcrs_top_tb;
    import pcrs_pkg::*;
    logic              clock;
    logic              rst_n;
    pcrs_wb_req_type   wb;
    pcrs_core_req_type core;
    logic [31:0]       wbDat;
    logic              wbAck;
    logic              full;
    logic              ovf;
    logic              unf;
    logic [20:0]       fetchAddr;
    logic [15:0]       progData;
    logic [15:0]       instrWord;
    logic [20:0]       fetchAddr16;
    logic [15:0]       progData16;
    logic [15:0]       instrWord16;
    logic [7:0]        q;
    int                mismatches;
    int                cmp_count;

    pcrs_top #(.MEM_KBYTES(8)) uut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb.cyc),
        .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_sel_i(wb.sel), .wb_adr_i(wb.adr),
        .wb_dat_i(wb.dat), .wb_dat_o(wbDat), .wb_ack_o(wbAck), .coreOp(core.op),
        .coreTarget(core.target), .progData(progData), .fetchAddr(fetchAddr),
        .instrWord(instrWord), .stackFull(full), .stackOverflow(ovf),
        .stackUnderflow(unf));
    pcrs_prog_mem mem (.fetchAddr(fetchAddr), .progData(progData));
    // larger build on the same stimulus, only its fetch path is judged
    pcrs_top #(.MEM_KBYTES(16)) uut16 (.clock(clock), .rst_n(rst_n), .wb_cyc_i(wb.cyc),
        .wb_stb_i(wb.stb), .wb_we_i(wb.we), .wb_sel_i(wb.sel), .wb_adr_i(wb.adr),
        .wb_dat_i(wb.dat), .wb_dat_o(), .wb_ack_o(), .coreOp(core.op),
        .coreTarget(core.target), .progData(progData16), .fetchAddr(fetchAddr16),
        .instrWord(instrWord16), .stackFull(), .stackOverflow(),
        .stackUnderflow());
    pcrs_prog_mem mem16 (.fetchAddr(fetchAddr16), .progData(progData16));

    // shared compare, counting every check
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", n, e, g);
            mismatches++;
        end
    endtask
    task automatic chkpc(input logic [20:0] e);
        chk("fetchAddr", {11'h000, e}, {11'h000, fetchAddr});
    endtask
    // classic cycle: hold until ack is seen at an edge, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        wb <= '{1'b1, 1'b1, w, 4'hF, a, {24'h000000, d}};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1);
        q = wbDat[7:0];
        wb <= '0;
        chk("ack wait", 32'h00000002, 32'(n));
        @(negedge clock);
    endtask
    // two core operations on consecutive edges
    task automatic op2(input pcrs_op_type a, input pcrs_op_type b, input logic [20:0] t);
        @(posedge clock);
        core <= '{a, t};
        @(posedge clock);
        core <= '{b, 21'h000000};
        @(posedge clock);
        core <= '{OP_NONE, 21'h000000};
        @(negedge clock);
    endtask
    task automatic rd(input string n, input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(n, {24'h000000, e}, {24'h000000, q});
    endtask
    task automatic op(input pcrs_op_type o, input logic [20:0] t);
        @(posedge clock);
        core <= '{o, t};
        @(posedge clock);
        core <= '{OP_NONE, 21'h000000};
        @(negedge clock);
    endtask
    task automatic idle();
        repeat (2) @(posedge clock);
        @(negedge clock);
    endtask

    task automatic t_reset();
        chkpc(21'h000000);
        rd("sp", OFS_STACK_PTR, 8'h00);
        chk("flags", 32'h00000000, {29'h0, full, ovf, unf});
    endtask
    task automatic t_seq();
        repeat (3) op(OP_ADVANCE, 21'h000000);
        chkpc(21'h000006);
        idle();
        chk("instr", 32'h0000FFFC, {16'h0000, instrWord});
    endtask
    task automatic t_int();
        op(OP_INT_HI, 21'h000000);
        chkpc(21'h000008);
        rd("sp", OFS_STACK_PTR, 8'h01);
        rd("topL", OFS_TOP_LOW, 8'h06);
        op(OP_INT_LO, 21'h000000);
        chkpc(21'h000018);
        rd("topL", OFS_TOP_LOW, 8'h08);
        op(OP_RETINT, 21'h000000);
        chkpc(21'h000008);
        op(OP_RETURN, 21'h000000);
        chkpc(21'h000006);
        rd("sp", OFS_STACK_PTR, 8'h00);
    endtask
    task automatic t_call();
        bus(1'b1, OFS_HIGH_LATCH, 8'h55);
        bus(1'b1, OFS_UPPER_LATCH, 8'h0A);
        op(OP_BRANCH, 21'h1ABCD);
        chkpc(21'h1ABCC);
        op(OP_CALL, 21'h000120);
        chkpc(21'h000120);
        rd("topU", OFS_TOP_UPPER, 8'h01);
        rd("topH", OFS_TOP_HIGH, 8'hAB);
        op(OP_RELCALL, 21'h000240);
        chkpc(21'h000240);
        op(OP_RETLIT, 21'h000000);
        chkpc(21'h000120);
        op(OP_RETURN, 21'h000000);
        chkpc(21'h1ABCC);
        op2(OP_CALL, OP_RETURN, 21'h000300);
        chkpc(21'h1ABCC);
        rd("latH", OFS_HIGH_LATCH, 8'h55);
        rd("latU", OFS_UPPER_LATCH, 8'h0A);
    endtask
    task automatic t_low();
        bus(1'b1, OFS_LOW_BYTE, 8'h37);
        chkpc(21'h0A5536);
        op(OP_BRANCH, 21'h13579A);
        rd("low", OFS_LOW_BYTE, 8'h9A);
        rd("latH", OFS_HIGH_LATCH, 8'h57);
        rd("latU", OFS_UPPER_LATCH, 8'h13);
    endtask
    // last implemented word, first absent word, top of the space
    task automatic t_bound();
        op(OP_BRANCH, 21'h001FFE);
        idle();
        chk("instr", 32'h0000F000, {16'h0000, instrWord});
        op(OP_BRANCH, 21'h002000);
        idle();
        chk("instr", 32'h00000000, {16'h0000, instrWord});
        chk("instr16", 32'h0000EFFF, {16'h0000, instrWord16});
        op(OP_BRANCH, 21'h004000);
        idle();
        chk("instr16", 32'h00000000, {16'h0000, instrWord16});
        op(OP_BRANCH, 21'h1FFFFE);
        idle();
        chk("instr", 32'h00000000, {16'h0000, instrWord});
    endtask
    task automatic t_limits();
        for (int i = 1; i <= 31; i++) op(OP_CALL, 21'(256 + 2 * i));
        chk("full", 32'h00000001, {31'h0, full});
        op(OP_CALL, 21'h000400);
        rd("sp", OFS_STACK_PTR, 8'hBF);
        chk("ovf", 32'h00000001, {31'h0, ovf});
        op(OP_RETURN, 21'h000000);
        chkpc(21'h00013C);
        rd("sp", OFS_STACK_PTR, 8'h9E);
        bus(1'b1, OFS_STACK_PTR, 8'h00);
        rd("sp", OFS_STACK_PTR, 8'h00);
        op(OP_RETURN, 21'h000000);
        chkpc(21'h000000);
        op(OP_ADVANCE, 21'h000000);
        chk("unf", 32'h00000001, {31'h0, unf});
        rd("sp", OFS_STACK_PTR, 8'h40);
    endtask
    // software push through the pointer and top registers with the core idle, then a core return pops it
    task automatic t_soft();
        bus(1'b1, OFS_STACK_PTR, 8'h02);
        bus(1'b1, OFS_TOP_UPPER, 8'h01);
        bus(1'b1, OFS_TOP_HIGH, 8'h23);
        bus(1'b1, OFS_TOP_LOW, 8'h44);
        rd("topH", OFS_TOP_HIGH, 8'h23);
        op(OP_RETURN, 21'h000000);
        chkpc(21'h012344);
        rd("sp", OFS_STACK_PTR, 8'h01);
        rd("unmapped", 8'h1C, 8'h00);
    endtask
    // second reset with a non-empty stack and a moved counter
    task automatic t_rerst();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        chkpc(21'h000000);
        chk("flags", 32'h00000000, {29'h0, full, ovf, unf});
        rd("sp", OFS_STACK_PTR, 8'h00);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // free-running core clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // reset, then scenarios in order
    initial begin
        rst_n = 1'b0;
        wb = '0;
        core = '{OP_NONE, 21'h000000};
        mismatches = 0;
        cmp_count = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        @(negedge clock);
        t_reset();
        t_seq();
        t_int();
        t_call();
        t_low();
        t_bound();
        t_limits();
        t_soft();
        t_rerst();
        complete_run();
    end
    // hang guard, well beyond the few hundred cycles needed
    initial begin
        repeat (5000) @(posedge clock);
        mismatches++;
        complete_run();
    end
endmodule
`default_nettype wire
